// >>> design/swst_triplet.sv
// Search triplet engine with AXI4-Lite register access
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
module swst_triplet (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Single-wire line
  input  wire logic        lineIn,
  output logic             lineOut,
  output logic             lineOe,
  output logic             activePullup,
  output logic             passivePullup,
  // Interrupt
  output logic             irq
);
  // Register state
  logic [7:0]  config_;
  logic [31:0] timing;
  logic [1:0]  irqStatus;
  logic [1:0]  irqMask;
  logic [1:0]  readPtr;
  logic        lineBusyFlag;
  logic        singleBitResult;
  logic        tripletSecondBit;
  logic        branchDir;
  logic        refused;
  // Engine state
  swst_pkg::swst_state_t state;
  swst_pkg::swst_state_t next_state;
  localparam swst_pkg::swst_state_t S_IDLE = swst_pkg::S_IDLE;
  localparam swst_pkg::swst_state_t S_WAIT = swst_pkg::S_WAIT;
  localparam swst_pkg::swst_state_t S_LOW  = swst_pkg::S_LOW;
  localparam swst_pkg::swst_state_t S_REL  = swst_pkg::S_REL;
  localparam swst_pkg::swst_state_t S_DONE = swst_pkg::S_DONE;
  logic [1:0]  slotIdx;
  logic        branchChoice;
  logic        timerLoad;
  logic [11:0] timerValue;
  logic        timerExpired;
  logic [11:0] slotElapsed;
  // Line input synchroniser
  logic        lineSync1;
  logic        lineSync2;
  // Bus handshake state
  logic        awHeld;
  logic        wHeld;
  logic [7:0]  awAddr;
  logic [31:0] wData;
  logic [3:0]  wStrb;
  logic        doWrite;
  logic        cmdAccept;
  logic        cmdRefuse;
  logic        slotEnd;
  logic        samplePoint;
  logic        speedOvd;
  logic [11:0] slotTime;
  logic [11:0] msrTime;
  logic [11:0] readLow;
  logic [11:0] w0Low;
  logic [11:0] w1Low;
  logic [11:0] recTime;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Slot parameters from current speed selection and timing register
  assign speedOvd = config_[swst_pkg::CFG_SPEED];
  assign slotTime = speedOvd ? swst_pkg::SLOT_OVD : swst_pkg::SLOT_STD; // see (R8)
  assign msrTime  = speedOvd ? swst_pkg::MSR_OVD : swst_pkg::MSR_STD;
  assign readLow  = speedOvd ? swst_pkg::RLOW_OVD : swst_pkg::RLOW_STD;
  assign w0Low    = timing[11:0];
  assign w1Low    = timing[27:16];
  assign recTime  = {4'h0, timing[31:28], 4'h0};

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lineSync1 <= 1'b1;
      lineSync2 <= 1'b1;
    end else begin
      lineSync1 <= lineIn;
      lineSync2 <= lineSync1;
    end
  end

  // Write channel: address and data taken in either order
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      awAddr <= 8'h00;
      wData  <= 32'h0000_0000;
      wStrb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  assign doWrite       = awHeld && wHeld && !s_axi_bvalid;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awAddr > swst_pkg::ADDR_PTR || awAddr[1:0] != 2'h0) ? 2'h2 : 2'h0;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Command write: branch choice in bit 7, rest ignored
  assign cmdAccept = doWrite && awAddr == swst_pkg::ADDR_CMD && wStrb[1] && wStrb[0]
                     && wData[15:8] == swst_pkg::CMD_TRIPLET && !lineBusyFlag;
  assign cmdRefuse = doWrite && awAddr == swst_pkg::ADDR_CMD && wStrb[1]
                     && wData[15:8] == swst_pkg::CMD_TRIPLET && lineBusyFlag; // see (R1)

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      config_ <= swst_pkg::CFG_RST;
      timing  <= swst_pkg::TIMING_RST;
      irqMask <= 2'h0;
    end else if (doWrite) begin
      if (awAddr == swst_pkg::ADDR_CONFIG && wStrb[0]) begin
        config_ <= wData[7:0];
      end
      if (awAddr == swst_pkg::ADDR_TIMING) begin
        timing <= merge_bytes(timing, wData, wStrb);
      end
      if (awAddr == swst_pkg::ADDR_IRQMSK && wStrb[0]) begin
        irqMask <= wData[1:0];
      end
    end
  end

  // Pointer moves to status on an accepted command
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      readPtr <= swst_pkg::PTR_STATUS;
    end else if (cmdAccept) begin
      readPtr <= swst_pkg::PTR_STATUS; // see (R4)
    end else if (doWrite && awAddr == swst_pkg::ADDR_PTR && wStrb[0]) begin
      readPtr <= wData[1:0];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      refused <= 1'b0;
    end else if (cmdRefuse) begin
      refused <= 1'b1;
    end else if (cmdAccept) begin
      refused <= 1'b0;
    end
  end

  // Sticky events; set wins over write-one clear
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irqStatus <= 2'h0;
    end else begin
      irqStatus <= (irqStatus & ~((doWrite && awAddr == swst_pkg::ADDR_IRQST && wStrb[0])
                   ? (wData[1:0] & swst_pkg::IRQ_W1C_MASK) : 2'h0))
                   | {cmdRefuse, state == S_DONE};
    end
  end

  assign irq = |(irqStatus & irqMask);

  // Read channel; pointer register selects status or config view at offset 0x00
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      unique case (s_axi_araddr)
        swst_pkg::ADDR_CMD:    s_axi_rdata <= (readPtr == swst_pkg::PTR_STATUS)
                                 ? {23'h0, refused, branchDir, tripletSecondBit,
                                    singleBitResult, 4'h0, lineBusyFlag}
                                 : {24'h0, config_};
        swst_pkg::ADDR_STATUS: s_axi_rdata <= {23'h0, refused, branchDir, tripletSecondBit,
                                               singleBitResult, 4'h0, lineBusyFlag};
        swst_pkg::ADDR_CONFIG: s_axi_rdata <= {24'h0, config_};
        swst_pkg::ADDR_TIMING: s_axi_rdata <= timing;
        swst_pkg::ADDR_IRQST:  s_axi_rdata <= {30'h0, irqStatus};
        swst_pkg::ADDR_IRQMSK: s_axi_rdata <= {30'h0, irqMask};
        swst_pkg::ADDR_PTR:    s_axi_rdata <= {30'h0, readPtr};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  // Slot sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      S_IDLE: if (cmdAccept) next_state = S_WAIT;
      S_WAIT: next_state = S_LOW; // see (R3)
      S_LOW:  if (timerExpired) next_state = S_REL;
      S_REL:  if (slotEnd) next_state = (slotIdx == 2'h2) ? S_DONE : S_LOW; // see (R12)
      S_DONE: next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Elapsed cycles inside the current slot
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      slotElapsed <= 12'h000;
    end else if (state == S_WAIT || (state == S_REL && slotEnd)) begin
      slotElapsed <= 12'h000;
    end else if (state == S_LOW || state == S_REL) begin
      slotElapsed <= slotElapsed + 12'h001;
    end
  end

  // Slot time plus recovery bounds each slot
  assign slotEnd     = slotElapsed >= slotTime + recTime - 12'h001;
  assign samplePoint = (state == S_LOW || state == S_REL) && !slotIdx[1] && slotElapsed == msrTime;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      slotIdx <= 2'h0;
    end else if (state == S_WAIT) begin
      slotIdx <= 2'h0;
    end else if (state == S_REL && slotEnd) begin
      slotIdx <= slotIdx + 2'h1;
    end
  end

  // Branch choice latched from the parameter byte
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      branchChoice <= 1'b0;
    end else if (cmdAccept) begin
      branchChoice <= wData[swst_pkg::BRANCH_BIT]; // see (R10)
    end
  end

  // Result flags; protection bit is never touched here
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      singleBitResult  <= 1'b0;
      tripletSecondBit <= 1'b0;
      branchDir        <= 1'b0;
    end else if (samplePoint && slotIdx == 2'h0) begin
      singleBitResult <= lineSync2; // see (R6) (R15) (R9)
    end else if (samplePoint && slotIdx == 2'h1) begin
      tripletSecondBit <= lineSync2; // see (R7) (R15)
      if (singleBitResult != lineSync2) begin
        branchDir <= singleBitResult; // see (R13)
      end else if (singleBitResult) begin
        branchDir <= 1'b1; // see (R14)
      end else begin
        branchDir <= branchChoice; // see (R11)
      end
    end
  end

  // Busy for the three slots, cleared when the last slot ends
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lineBusyFlag <= 1'b0;
    end else if (cmdAccept) begin
      lineBusyFlag <= 1'b1; // see (R5)
    end else if (state == S_DONE) begin
      lineBusyFlag <= 1'b0; // see (R2)
    end
  end

  always_comb begin
    timerLoad  = 1'b0;
    timerValue = readLow;
    if (next_state == S_LOW && state != S_LOW) begin
      timerLoad = 1'b1;
      if (slotIdx == 2'h2 || (state == S_REL && slotIdx == 2'h1)) begin
        timerValue = branchDir ? w1Low : w0Low;
      end
    end
  end

  swst_slot_timer u_timer (
    .clock     (clock),
    .reset_n   (reset_n),
    .load      (timerLoad),
    .loadValue (timerValue),
    .expired   (timerExpired)
  );

  // Line drive: low phase pulls down; active pullup helps the release
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lineOut       <= 1'b1;
      lineOe        <= 1'b0;
      activePullup  <= 1'b0;
      passivePullup <= 1'b0;
    end else begin
      lineOut       <= 1'b0;
      lineOe        <= (next_state == S_LOW); // see (R8)
      activePullup  <= config_[swst_pkg::CFG_APU] && state == S_LOW && timerExpired;
      passivePullup <= config_[swst_pkg::CFG_PASSIVE_PULLUP_RESISTANCE];
    end
  end
endmodule

// >>> design/swst_pkg.sv
// Constants and types for the single-wire search triplet engine
// Behaviour
// (R1) Busy flag set: command code not acknowledged, ignored
// (R2) Command done within three slots plus margin
// (R3) Line driven within margin after parameter acknowledge
// (R4) Accepted command points read pointer at status
// (R5) Busy flag high for three slot times
// (R6) Single bit result updated at first sample
// (R7) Second bit and direction updated at second sample
// (R8) Slots use speed, pullup and timing settings
// (R9) Memory protection status left unchanged
// (R10) Branch choice is parameter bit 7 only
// (R11) Both reads zero: write slot follows branch choice
// (R12) Exactly two read slots then one write
// (R13) Reads 0,1 write zero; reads 1,0 write one
// (R14) Both reads one: still write one
// (R15) Flags hold read values and written value
package swst_pkg;
  localparam logic [7:0] CMD_TRIPLET = 8'h78;
  localparam int         BRANCH_BIT  = 7;
  // Register byte addresses
  localparam logic [7:0] ADDR_CMD    = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CONFIG = 8'h08;
  localparam logic [7:0] ADDR_TIMING = 8'h0c;
  localparam logic [7:0] ADDR_IRQST  = 8'h10;
  localparam logic [7:0] ADDR_IRQMSK = 8'h14;
  localparam logic [7:0] ADDR_PTR    = 8'h18;
  // Status bit positions
  localparam int ST_BUSY    = 0;
  localparam int ST_SBR     = 5;
  localparam int ST_TSB     = 6;
  localparam int ST_DIR     = 7;
  localparam int ST_REFUSED = 8;
  // Config bit positions
  localparam int CFG_SPEED  = 0;
  localparam int CFG_APU    = 1;
  localparam int CFG_PASSIVE_PULLUP_RESISTANCE   = 2;
  localparam int CFG_PROT   = 3;
  // Interrupt bits
  localparam int IRQ_DONE   = 0;
  localparam int IRQ_REFUSE = 1;
  localparam logic [1:0] IRQ_W1C_MASK = 2'h3;
  // Read pointer codes
  localparam logic [1:0] PTR_STATUS = 2'h0;
  localparam logic [1:0] PTR_DATA   = 2'h1;
  // Timing: start margin in nanoseconds and clock rate in MHz
  localparam int CLK_MHZ          = 40;
  localparam int START_MARGIN_NS  = 1090;
  localparam int START_CYC        = (START_MARGIN_NS * CLK_MHZ) / 1000;
  // Slot timing defaults in clock cycles (standard / overdrive)
  localparam logic [11:0] SLOT_STD    = 12'h960;
  localparam logic [11:0] SLOT_OVD    = 12'h118;
  localparam logic [11:0] MSR_STD     = 12'h0c8;
  localparam logic [11:0] MSR_OVD     = 12'h028;
  localparam logic [11:0] RLOW_STD    = 12'h028;
  localparam logic [11:0] RLOW_OVD    = 12'h00a;
  localparam logic [31:0] TIMING_RST  = 32'h0078_0fa0;
  localparam logic [7:0]  CFG_RST     = 8'h00;
  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_WAIT  = 5'b00010,
    S_LOW   = 5'b00100,
    S_REL   = 5'b01000,
    S_DONE  = 5'b10000
  } swst_state_t;
endpackage

// >>> design/swst_slot_timer.sv
// Cycle counter that times the low phase of each slot
`timescale 1ns/100ps
module swst_slot_timer (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // Control
  input  wire logic        load,
  input  wire logic [11:0] loadValue,
  // Status
  output logic             expired
);
  logic [11:0] count;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count <= 12'h000;
    end else if (load) begin
      count <= loadValue;
    end else if (count != 12'h000) begin
      count <= count - 12'h001;
    end
  end

  assign expired = (count == 12'h000) && !load;
endmodule

// >>> sim/swst_triplet_props.sv
// Port assertions for the search triplet engine
`timescale 1ns/100ps
module swst_triplet_props (
  // Clock and reset
  input wire logic        clock,
  input wire logic        reset_n,
  // Register bus
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Line
  input wire logic        lineOut,
  input wire logic        lineOe,
  input wire logic        activePullup
);
  localparam int START_MAX = 43;
  logic [11:0] quietCnt;
  // Long quiet: no triplet can still run, even at standard speed
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n)
      quietCnt <= 12'h000;
    else if (lineOe)
      quietCnt <= 12'h000;
    else if (quietCnt != 12'hfff)
      quietCnt <= quietCnt + 12'h001;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  line_start_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && quietCnt >= 12'hbb8
    && s_axi_awaddr == swst_pkg::ADDR_CMD && s_axi_wdata[15:8] == swst_pkg::CMD_TRIPLET
    |-> ##[1:START_MAX] lineOe) else $error("line not driven after command");
  pull_low_a: assert property (lineOe |-> !lineOut) else $error("line driven high");
  low_min_a: assert property ($rose(lineOe) |-> lineOe[*8])
    else $error("low phase too short");
  release_min_a: assert property ($fell(lineOe) |-> !lineOe[*8])
    else $error("slots run together");
  pullup_idle_a: assert property (activePullup |-> !lineOe)
    else $error("pullup while line driven");
  // Both halves are held one cycle before the response is registered
  write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
  read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read response changed");
endmodule

bind swst_triplet swst_triplet_props u_props (
  .clock(clock), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .lineOut(lineOut), .lineOe(lineOe),
  .activePullup(activePullup));

// >>> sim/swst_slave_model.sv
// Behavioural slave on the single-wire line
`timescale 1ns/100ps
module swst_slave_model #(
  parameter int HOLD = 240
) (
  // Clock
  input  wire logic       clock,
  // Line
  input  wire logic       lineOe,
  output logic            slaveLow,
  // Scenario control
  input  wire logic [1:0] replyBits,
  output logic            writtenBit,
  output int              slotCount
);
  int   holdCnt;
  int   lowLen;
  logic oeLast;
  initial begin
    slaveLow = 1'b0;
    writtenBit = 1'b0;
    slotCount = 0;
    holdCnt = 0;
    lowLen = 0;
    oeLast = 1'b0;
  end
  always @(posedge clock) begin
    oeLast <= lineOe;
    if (lineOe)
      lowLen <= lowLen + 1;
    if (lineOe && !oeLast) begin
      lowLen <= 1;
      slotCount <= slotCount + 1;
      // A zero is answered by holding the line past the sample point
      if (slotCount % 3 < 2 && !replyBits[slotCount % 3]) begin
        slaveLow <= 1'b1;
        holdCnt <= HOLD;
      end
    end else if (holdCnt > 0)
      holdCnt <= holdCnt - 1;
    else
      slaveLow <= 1'b0;
    if (!lineOe && oeLast && slotCount % 3 == 0)
      writtenBit <= (lowLen < 50);
  end
endmodule

// >>> sim/tb_single_wire_search_triplet.sv
// Self-checking bench for the search triplet engine
`timescale 1ns/100ps
module tb_single_wire_search_triplet;
  logic        clock, reset_n, lineIn, lineOut, lineOe, activePullup, passivePullup, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rData;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rResp, replyBits;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, slaveLow, writtenBit;
  int          slotCount, err_total, n_compared, cyc, i;

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) cyc <= cyc + 1;
  assign lineIn = ~((lineOe & ~lineOut) | slaveLow);

  swst_triplet DUT (
    .clock(clock), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .lineIn(lineIn),
    .lineOut(lineOut), .lineOe(lineOe), .activePullup(activePullup),
    .passivePullup(passivePullup), .irq(irq));
  swst_slave_model u_slave (.clock(clock), .lineOe(lineOe), .slaveLow(slaveLow),
    .replyBits(replyBits), .writtenBit(writtenBit), .slotCount(slotCount));

  task automatic report_and_stop;
    $display("Mismatches %0d, comparisons %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, done;
    // Fresh edge, so no handshake signal is driven twice in one step
    @(posedge clock);
    aw = 1'b1;
    w = 1'b1;
    done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(posedge clock);
      done = !aw && !w && s_axi_bvalid;
      if (done)
        s_axi_bready <= 1'b0;
      if (aw && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (w && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
    end
    if (!done) begin
      chk("write wait", 1, 0);
      report_and_stop();
    end
  endtask

  task automatic rd(input logic [7:0] a);
    logic ar, done;
    @(posedge clock);
    ar = 1'b1;
    done = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(posedge clock);
      done = !ar && s_axi_rvalid;
      rData = s_axi_rdata;
      rResp = s_axi_rresp;
      if (done)
        s_axi_rready <= 1'b0;
      if (ar && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      ar = ar && !s_axi_arready;
    end
    if (!done) begin
      chk("read wait", 1, 0);
      report_and_stop();
    end
  endtask

  task automatic triplet(input logic [1:0] rb, input logic v, input int slot, input logic rf,
                         input logic im);
    int   n, t0, k;
    logic e;
    // Reads differ: first read wins; equal: ones force one, zeros take v
    e = (rb[0] != rb[1]) ? rb[0] : (rb[0] | v);
    n = slotCount;
    replyBits <= rb;
    wr(swst_pkg::ADDR_PTR, {30'h0, swst_pkg::PTR_DATA});
    wr(swst_pkg::ADDR_CMD, {16'h0000, swst_pkg::CMD_TRIPLET, v, 7'($urandom)});
    t0 = cyc;
    if (rf) begin
      wr(swst_pkg::ADDR_CMD, {16'h0000, swst_pkg::CMD_TRIPLET, ~v, 7'h00});
      rd(swst_pkg::ADDR_STATUS);
      chk("refused", 1, rData[swst_pkg::ST_REFUSED]);
    end
    rd(swst_pkg::ADDR_CMD);
    chk("busy", 1, rData[swst_pkg::ST_BUSY]);
    for (k = 0; k < 4000 && rData[swst_pkg::ST_BUSY] !== 1'b0; k++)
      rd(swst_pkg::ADDR_CMD);
    if (rData[swst_pkg::ST_BUSY] !== 1'b0) begin
      chk("busy end", 0, 1);
      report_and_stop();
    end
    k = cyc - t0;
    chk("duration", 1, k >= 3 * slot - 8 && k <= 3 * (slot + 16) + 51);
    chk("slots", 3, slotCount - n);
    chk("written", e, writtenBit);
    chk("results", {e, rb[1], rb[0]}, rData[7:5]);
    chk("irq", im, irq);
    rd(swst_pkg::ADDR_IRQST);
    chk("done flag", 1, rData[swst_pkg::IRQ_DONE]);
    wr(swst_pkg::ADDR_IRQST, 32'h0000_0003);
    chk("irq clear", 0, irq);
    rd(swst_pkg::ADDR_CONFIG);
    chk("protect", 1, rData[swst_pkg::CFG_PROT]);
  endtask

  initial begin
    void'($urandom(32'h6a96));
    {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, replyBits, cyc} = '0;
    s_axi_wstrb = 4'hf;
    err_total = 0;
    n_compared = 0;
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    rd(swst_pkg::ADDR_STATUS);
    chk("status reset", 0, rData);
    rd(swst_pkg::ADDR_IRQST);
    chk("irq reset", 0, rData);
    rd(8'h1c);
    chk("unmapped resp", 2, rResp);
    chk("unmapped data", 0, rData);
    wr(swst_pkg::ADDR_TIMING, 32'h100a_0064);
    wr(swst_pkg::ADDR_CONFIG, 32'h0000_000f);
    // Pullup output lags the config register by one cycle
    wr(swst_pkg::ADDR_IRQMSK, 32'h0000_0003);
    chk("passive pullup", 1, passivePullup);
    for (i = 0; i < 8; i++)
      triplet(i[1:0], i[2], 280, i == 0, 1'b1);
    // Standard speed, masked, started from a quiet line
    wr(swst_pkg::ADDR_IRQMSK, 32'h0000_0000);
    wr(swst_pkg::ADDR_CONFIG, 32'h0000_000e);
    repeat (3000) @(posedge clock);
    triplet(2'($urandom), 1'($urandom), 2400, 1'b0, 1'b0);
    report_and_stop();
  end
endmodule
